// >>> hw/rgp_ctrl.sv
// Functional notes
// RULE1: On-contact closed turns rows on, pulsing. The code only starts from off while link_lost is low.
// RULE2: Caution on any light, node, module failure.
// RULE3: Fault on two adjacent or three lights.
// RULE4: Caution and fault on separate outputs.
// RULE5: Reset contact clears caution; caution can re-raise.
// RULE6: Fault stays until failure corrected.
// RULE7: Caution always active while fault active.
// RULE8: Even lights together, odd lights alternately.
// RULE9: Each set powered half the cycle.
// RULE10: Thirty to thirty-two flashes per minute.
// RULE11: Failed lamp leaves others pulsing normally.
// RULE12: Link loss: keep pulsing eight hours.
// RULE13: Sets stay synchronised within 0.05 s.
// RULE14: Even opposite odd within 0.13 s.
// RULE15: Failed local control device forces lamps off.
// RULE16: Link loss separate from component failure.
// RULE17: Vault computer checks regulator output current.
// RULE18: Caution latched until reset contact closes.
`timescale 1ns/10ps
`default_nettype none
module rgp_ctrl
	import rgp_pkg::*;
#(
	parameter longint HOLD_CYCLES = HOLDOVER_CYCLES,
	parameter longint HALF = HALF_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Vault contacts
	input wire logic on_contact,
	input wire logic reset_contact,
	// Field status
	input wire logic [ROWS*LIGHTS-1:0] lamp_failed,
	input wire logic [ROWS*NODES-1:0] node_failed,
	input wire logic [ROWS*NODES-1:0] node_link_lost,
	input wire logic io_module_failed,
	// Lamp drive
	output logic [ROWS*LIGHTS-1:0] lamp_on,
	// Alarm contacts
	output logic caution_out,
	output logic fault_out,
	// Avalon-MM slave
	input wire rgp_av_req_t av_req,
	output rgp_av_rsp_t av_rsp,
	output logic irq
);
	localparam int NPER = LIGHTS / NODES;

	rgp_state_t state_q;
	logic phase_q;
	logic [31:0] tick_q;
	logic [47:0] hold_q;
	logic caution_q, fault_q, reset_d1_q;
	logic [2:0] ctrl_q;
	logic [2:0] irq_stat_q, irq_mask_q;
	logic [31:0] rdata_q;
	logic rvalid_q;
	logic [ROWS-1:0] row_fault;
	logic link_lost, any_fail, active, fault_rise, caution_rise, link_rise;
	logic link_lost_q;
	logic [31:0] status_word;

	// Count failed lamps in one row and check adjacency
	function automatic logic row_bad(input logic [LIGHTS-1:0] f);
		int cnt;
		logic adj;
		cnt = 0;
		adj = 1'b0;
		for (int i = 0; i < LIGHTS; i++) begin
			cnt += int'(f[i]);
			if (i > 0 && f[i] && f[i-1]) begin
				adj = 1'b1;
			end
		end
		return adj || (cnt >= 3);
	endfunction : row_bad

	// Write decode shared by every register that software can change
	function automatic logic wr_hit(input rgp_av_req_t req, input logic [7:0] off);
		return req.write && (req.address == off);
	endfunction : wr_hit

	genvar r, l;
	generate
		for (r = 0; r < ROWS; r++) begin : g_row
			assign row_fault[r] = row_bad(lamp_failed[r*LIGHTS +: LIGHTS]); // RULE3
			for (l = 0; l < LIGHTS; l++) begin : g_lamp
				// One phase signal feeds every lamp, so sets never skew
				assign lamp_on[r*LIGHTS+l] = (state_q != RGP_OFF)
					&& ((l % 2 == 0) ? !phase_q : phase_q) // RULE8 RULE13 RULE14
					&& !node_failed[r*NODES + l/NPER]; // RULE15 RULE11
			end
		end
	endgenerate

	// Link loss kept apart from component failures
	assign link_lost = |node_link_lost || !ctrl_q[CTRL_LINK_OK]; // RULE16
	assign any_fail = |lamp_failed || |node_failed || io_module_failed; // RULE2
	assign active = on_contact || ctrl_q[CTRL_ON];

	// Flash sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= RGP_OFF;
			hold_q <= '0;
		end else begin
			unique case (state_q)
				RGP_OFF: if (active && !link_lost) state_q <= RGP_RUN; // RULE1
				RGP_RUN: begin
					if (link_lost) begin
						state_q <= RGP_HOLD; // RULE12
						hold_q <= '0;
					end else if (!active) begin
						state_q <= RGP_OFF;
					end
				end
				RGP_HOLD: begin
					hold_q <= hold_q + 48'h1;
					if (!link_lost) state_q <= active ? RGP_RUN : RGP_OFF;
					else if (hold_q >= 48'(HOLD_CYCLES - 1)) state_q <= RGP_OFF; // RULE12
				end
			endcase
		end
	end

	// Half-period timer; exact equal halves keep duty at 50 percent
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick_q <= '0;
			phase_q <= RST_PHASE;
		end else if (state_q == RGP_OFF) begin
			tick_q <= '0;
			phase_q <= RST_PHASE;
		end else if (tick_q >= 32'(HALF - 1)) begin
			tick_q <= '0;
			phase_q <= !phase_q; // RULE9 RULE10
		end else begin
			tick_q <= tick_q + 32'h1;
		end
	end

	// Alarms: caution latched until reset closure, fault follows condition
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			caution_q <= 1'b0;
			fault_q <= 1'b0;
			reset_d1_q <= 1'b0;
		end else begin
			reset_d1_q <= reset_contact;
			fault_q <= |row_fault; // RULE6
			// A standing failure wins over a reset closure, so caution cannot blink off
			if (any_fail) caution_q <= 1'b1; // RULE2 RULE18
			else if (reset_contact && !reset_d1_q) caution_q <= 1'b0; // RULE5
		end
	end

	assign caution_out = caution_q || fault_q; // RULE4 RULE7
	assign fault_out = fault_q; // RULE4

	// Event detection for interrupts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) link_lost_q <= 1'b0;
		else link_lost_q <= link_lost;
	end
	assign caution_rise = any_fail && !caution_q;
	assign fault_rise = |row_fault && !fault_q;
	assign link_rise = link_lost && !link_lost_q;

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_stat_q <= '0;
		end else begin
			logic [2:0] clr;
			clr = '0;
			if (wr_hit(av_req, REG_IRQ_STAT)) clr = av_req.writedata[2:0];
			irq_stat_q <= (irq_stat_q & ~clr) | {link_rise, fault_rise, caution_rise};
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// Register writes; link-ok bit defaults set so the bench starts healthy
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_q <= 3'h2;
			irq_mask_q <= '0;
		end else begin
			if (wr_hit(av_req, REG_CTRL)) ctrl_q <= av_req.writedata[2:0];
			if (wr_hit(av_req, REG_IRQ_MASK)) irq_mask_q <= av_req.writedata[2:0];
		end
	end

	// Status word laid out by the shared bit positions
	always_comb begin
		status_word = 32'h0;
		status_word[ST_CAUTION] = caution_out;
		status_word[ST_FAULT] = fault_q;
		status_word[ST_HOLDOVER] = (state_q == RGP_HOLD);
		status_word[ST_PHASE] = phase_q;
	end

	// Reads answer one cycle late; waitrequest holds the master meanwhile
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= av_req.read && !rvalid_q;
			if (av_req.read && !rvalid_q) begin
				unique case (av_req.address)
					REG_CTRL: rdata_q <= {29'h0, ctrl_q};
					REG_STATUS: rdata_q <= status_word;
					REG_IRQ_STAT: rdata_q <= {29'h0, irq_stat_q};
					REG_IRQ_MASK: rdata_q <= {29'h0, irq_mask_q};
					REG_ROW_STATE: rdata_q <= {{(32-ROWS){1'b0}}, row_fault};
					default: rdata_q <= 32'h0;
				endcase
			end
		end
	end

	// One driver for the whole answer struct
	assign av_rsp = '{waitrequest: av_req.read && !rvalid_q, readdata: rdata_q};
endmodule : rgp_ctrl
`default_nettype wire

// >>> include/rgp_pkg.sv
package rgp_pkg;
	// Row geometry
	localparam int ROWS = 4;
	localparam int LIGHTS = 16;
	localparam int NODES = 4;

	// Clock and timing
	localparam longint CLK_HZ = 125000000;
	localparam longint FLASH_PER_MIN = 31;
	localparam longint HALF_CYCLES = (CLK_HZ * 60) / (FLASH_PER_MIN * 2);
	localparam longint HOLDOVER_HOURS = 8;
	localparam longint HOLDOVER_CYCLES = CLK_HZ * 3600 * HOLDOVER_HOURS;

	// Reset values
	localparam logic RST_PHASE = 1'b0;

	// Avalon-MM register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] REG_ROW_STATE = 8'h10;

	// Bit positions
	localparam int CTRL_ON = 0;
	localparam int CTRL_LINK_OK = 1;
	localparam int ST_CAUTION = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_HOLDOVER = 2;
	localparam int ST_PHASE = 3;
	localparam int IRQ_CAUTION = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_LINK = 2;

	// Avalon-MM request
	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} rgp_av_req_t;

	// Avalon-MM answer
	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} rgp_av_rsp_t;

	// Flash state
	typedef enum logic [1:0] {
		RGP_OFF,
		RGP_RUN,
		RGP_HOLD
	} rgp_state_t;
endpackage : rgp_pkg

// >>> test/rgp_vault.sv
`timescale 1ns/10ps
`default_nettype none
module rgp_vault (
	// Clock
	input wire logic clk_sys,
	// Operator request and regulator current sense
	input wire logic cmd_on,
	input wire logic current_ok,
	// Contact toward the controller
	output logic on_contact
);
	// Close only with loop current seen, so a dead loop never reads as lit
	always_ff @(posedge clk_sys) begin
		on_contact <= cmd_on & current_ok;
	end
endmodule : rgp_vault
`default_nettype wire

// >>> test/rgp_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module rgp_ctrl_checker
	import rgp_pkg::*;
#(
	parameter longint HALF = HALF_CYCLES
) (
	// Clock and contacts
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reset_contact,
	// Field status
	input wire logic [ROWS*LIGHTS-1:0] lamp_failed,
	input wire logic [ROWS*NODES-1:0] node_failed,
	input wire logic io_module_failed,
	// Outputs
	input wire logic [ROWS*LIGHTS-1:0] lamp_on,
	input wire logic caution_out,
	input wire logic fault_out
);
	localparam logic [63:0] EVEN = 64'h5555_5555_5555_5555;
	logic [63:0] dead;
	logic row_bad, any_fail, ev, od, ev_q;
	logic [31:0] cnt_q;
	// Row alarm condition and lamps behind failed nodes
	always_comb begin
		row_bad = 1'b0;
		for (int r = 0; r < ROWS; r++)
			row_bad |= |(lamp_failed[r*LIGHTS+:LIGHTS] & (lamp_failed[r*LIGHTS+:LIGHTS] >> 1))
				| ($countones(lamp_failed[r*LIGHTS+:LIGHTS]) > 2);
		for (int i = 0; i < ROWS*LIGHTS; i++)
			dead[i] = node_failed[i/4];
	end
	assign any_fail = |lamp_failed || |node_failed || io_module_failed;
	assign ev = |(lamp_on & EVEN);
	assign od = |(lamp_on & ~EVEN);
	// Length of the even stretch; counted here as repetition bounds cannot hold it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ev_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			ev_q <= ev;
			cnt_q <= (ev != ev_q) ? 32'h1 : cnt_q + 32'h1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_reset_idle; !reset_contact [*3]; endsequence
	sequence s_clean_rise; $rose(reset_contact) && !fault_out ##0 !any_fail [*4]; endsequence
	a_fault_rows: assert property (1'b1 |=> fault_out == $past(row_bad))
		else $error("fault contact wrong");
	a_caution_cover: assert property (fault_out |-> caution_out)
		else $error("fault without caution");
	a_caution_raise: assert property (any_fail |=> caution_out)
		else $error("caution not raised");
	a_caution_held: assert property (s_reset_idle ##0 caution_out |=> caution_out)
		else $error("caution dropped");
	a_reset_clear: assert property (s_clean_rise |-> !caution_out)
		else $error("caution not cleared");
	a_even_together: assert property (ev |-> lamp_on == (EVEN & ~dead))
		else $error("even set split");
	a_odd_opposed: assert property (od |-> lamp_on == (~EVEN & ~dead))
		else $error("odd set split");
	a_dead_dark: assert property ((lamp_on & dead) == 64'h0)
		else $error("lamp lit on failed node");
	a_half_period: assert property ($fell(ev) && od |-> cnt_q >= HALF - 1 && cnt_q <= HALF + 1)
		else $error("half period wrong");
endmodule : rgp_ctrl_checker
bind rgp_ctrl rgp_ctrl_checker #(.HALF(HALF)) i_chk (.clk_sys, .rst, .reset_contact,
	.lamp_failed, .node_failed, .io_module_failed, .lamp_on, .caution_out, .fault_out);
`default_nettype wire

// >>> test/rgp_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rgp_ctrl_tb
	import rgp_pkg::*;
;
	localparam logic [63:0] EV = 64'h5555_5555_5555_5555;
	logic clk_sys = 1'b0, rst = 1'b1, cmd_on = 1'b0, reset_contact = 1'b0, io_module_failed = 1'b0;
	logic on_contact, caution_out, fault_out, irq;
	logic [63:0] lamp_failed = '0, lamp_on;
	logic [15:0] node_failed = '0, node_link_lost = '0;
	logic [15:0] pat [3] = '{16'h0003, 16'h0015, 16'h0005};
	rgp_av_req_t av_req = '0;
	rgp_av_rsp_t av_rsp;
	logic [31:0] exp_q [$];
	int n_mismatch = 0, n_checks = 0, cyc = 0, r, n;
	rgp_vault i_vault (.clk_sys, .cmd_on, .current_ok(1'b1), .on_contact);
	rgp_ctrl #(.HOLD_CYCLES(100), .HALF(10)) i_dut (.clk_sys, .rst, .on_contact, .reset_contact,
		.lamp_failed, .node_failed, .node_link_lost, .io_module_failed, .lamp_on, .caution_out,
		.fault_out, .av_req, .av_rsp, .irq);
	initial forever #4 clk_sys = ~clk_sys;
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick
	// Reads note their expected word; the monitor below compares it
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		av_req <= '{~wr, wr, a, d};
		if (!wr) exp_q.push_back(d);
		do @(posedge clk_sys); while (av_rsp.waitrequest);
		av_req <= '0;
	endtask : bus
	task automatic pulse_reset();
		@(posedge clk_sys);
		reset_contact <= 1'b1;
		@(posedge clk_sys);
		reset_contact <= 1'b0;
		tick(4);
	endtask : pulse_reset
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	// Read data are taken only at the edge where waitrequest is low
	always @(posedge clk_sys) begin
		if (av_req.read && !av_rsp.waitrequest) check(av_rsp.readdata, exp_q.pop_front());
	end
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h3566FF9C));
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		bus(0, REG_CTRL, 32'h1 << CTRL_LINK_OK);
		bus(1, REG_IRQ_MASK, 32'h5);
		bus(0, REG_IRQ_MASK, 32'h5);
		bus(0, 8'h40, 32'h0);
		bus(1, REG_IRQ_MASK, 32'h0);
		$display("registers done");
		@(posedge clk_sys);
		cmd_on <= 1'b1;
		tick(2);
		check(lamp_on, EV);
		tick(10);
		check(lamp_on, ~EV);
		$display("pulsing done");
		// Adjacent pair, three apart, two apart
		for (int k = 0; k < 3; k++) begin
			r = $urandom_range(3);
			@(posedge clk_sys);
			lamp_failed <= 64'(pat[k] << $urandom_range(8)) << (r * 16);
			tick(2);
			check(fault_out, k < 2);
			check(caution_out, 1'b1);
			check((lamp_on === EV) || (lamp_on === ~EV), 1'b1);
			bus(0, REG_ROW_STATE, (k < 2) ? 32'h1 << r : 32'h0);
			pulse_reset();
			check(fault_out, k < 2);
			check(caution_out, 1'b1);
			@(posedge clk_sys);
			lamp_failed <= '0;
			tick(2);
			check(caution_out, 1'b1);
			pulse_reset();
			check(caution_out, 1'b0);
		end
		$display("lamp failures done");
		n = $urandom_range(15);
		@(posedge clk_sys);
		node_failed <= 16'h1 << n;
		io_module_failed <= 1'b1;
		tick(2);
		check(lamp_on[n*4+:4], 4'h0);
		check(caution_out, 1'b1);
		@(posedge clk_sys);
		node_failed <= '0;
		io_module_failed <= 1'b0;
		pulse_reset();
		check(irq, 1'b0);
		bus(1, REG_IRQ_MASK, 32'h3);
		tick(1);
		check(irq, 1'b1);
		bus(1, REG_IRQ_STAT, 32'h7);
		tick(1);
		check(irq, 1'b0);
		bus(0, REG_IRQ_STAT, 32'h0);
		$display("node and irq done");
		@(posedge clk_sys);
		node_link_lost <= 16'h1 << n;
		tick(50);
		check(|lamp_on, 1'b1);
		check(caution_out, 1'b0);
		bus(0, REG_IRQ_STAT, 32'h1 << IRQ_LINK);
		tick(70);
		check(lamp_on, 64'h0);
		$display("link loss done");
		report_and_stop();
	end
endmodule : rgp_ctrl_tb
`default_nettype wire
